// >>> core/ster_pkg.sv
// shared constants and types for the serial transfer error reporter
package ster_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ASSIGN = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0c;
  localparam logic [7:0] OFS_CODE   = 8'h10;
  // status and mask bit positions
  localparam int ST_FRAME   = 0;
  localparam int ST_VALUE   = 1;
  localparam int ST_NAK_RX  = 2;
  localparam int ST_NAK_TX  = 3;
  localparam int ST_BAUD    = 4;
  localparam int ST_ASSIGN  = 5;
  localparam int ST_NOTRDY  = 6;
  localparam int ST_INCOMPL = 7;
  localparam int ST_W       = 8;
  // ctrl and assign field positions
  localparam int CT_BAUD_A  = 0;
  localparam int CT_BAUD_B  = 4;
  localparam int CT_ACT_A   = 8;
  localparam int CT_ACT_B   = 9;
  localparam int CT_W       = 10;
  localparam int AS_IFACE   = 8;
  // code register field positions
  localparam int CD_CLASS   = 12;
  localparam int CD_LETTER  = 16;
  localparam int CD_DSR     = 24;
  // characters, 7-bit ascii
  localparam logic [6:0] CH_SOH   = 7'h01;
  localparam logic [6:0] CH_ETB   = 7'h17;
  localparam logic [6:0] CH_SP    = 7'h20;
  localparam logic [6:0] CH_E     = 7'h45;
  localparam logic [6:0] CH_R     = 7'h52;
  localparam logic [6:0] CH_COLON = 7'h3a;
  localparam logic [6:0] CH_ZERO  = 7'h30;
  localparam logic [6:0] CH_NINE  = 7'h39;
  localparam logic [6:0] LT_BASE  = 7'h40;
  localparam logic [6:0] LT_H     = 7'h48;
  localparam logic [6:0] LT_K     = 7'h4b;
  localparam logic [6:0] LT_M     = 7'h4d;
  localparam logic [6:0] LT_N     = 7'h4e;
  localparam logic [2:0] HDR_LAST = 3'h6;
  localparam logic [1:0] DIG_LAST = 2'h2;
  localparam logic [11:0] NUM_FAULTY = 12'h003;
  localparam logic [2:0] NAK_LIMIT = 3'h3;
  // operating modes held per interface
  typedef enum logic [1:0] {
    MD_NONE   = 2'h0,
    MD_TAPE   = 2'h1,
    MD_FLOPPY = 2'h2,
    MD_EXT    = 2'h3
  } ster_mode_e;
  // error number classes
  typedef enum logic [1:0] {
    CL_NONE = 2'h0,
    CL_IO   = 2'h1,
    CL_RW   = 2'h2,
    CL_DISK = 2'h3
  } ster_class_e;
  typedef enum logic [4:0] {
    PS_IDLE = 5'b00001,
    PS_HDR  = 5'b00010,
    PS_DIG  = 5'b00100,
    PS_ETB  = 5'b01000,
    PS_BCC  = 5'b10000
  } ster_pstate_e;
endpackage : ster_pkg

// >>> core/ster_frm_if.sv
// character stream into the reply frame parser and its verdict
`timescale 1ns/10ps
interface ster_frm_if;
  logic        rx_valid;
  logic [7:0]  rx_char;
  logic        done;
  logic        ok;
  logic [11:0] num;
  modport parser (input rx_valid, rx_char, output done, ok, num);
  modport user   (output rx_valid, rx_char, input done, ok, num);
endinterface : ster_frm_if

// >>> core/ster_frame_parser.sv
// parser for the floppy unit error reply frame
`timescale 1ns/10ps
module ster_frame_parser (
  input  wire logic   pclk,
  input  wire logic   presetn,
  ster_frm_if.parser  frm
);
  import ster_pkg::*;

  ster_pstate_e st_q;
  logic [2:0]   idx_q;
  logic [6:0]   bcc_q;
  logic [6:0]   ch;
  logic         par_bad;
  logic         hdr_hit;
  logic         is_digit;

  function automatic logic [6:0] hdr_char(input logic [2:0] i);
    case (i)
      3'h0:    hdr_char = CH_E;
      3'h1:    hdr_char = CH_R;
      3'h2:    hdr_char = CH_R;
      3'h3:    hdr_char = CH_COLON;
      default: hdr_char = CH_SP;
    endcase
  endfunction : hdr_char

  assign ch       = frm.rx_char[6:0];
  assign par_bad  = ^frm.rx_char;
  assign hdr_hit  = (ch == hdr_char(idx_q));
  assign is_digit = (ch >= CH_ZERO) && (ch <= CH_NINE);

  // a bad character inside the frame closes it as a faulty transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q     <= PS_IDLE;
      idx_q    <= 3'h0;
      bcc_q    <= 7'h00;
      frm.done <= 1'b0;
      frm.ok   <= 1'b0;
      frm.num  <= 12'h000;
    end else begin
      frm.done <= 1'b0;
      if (frm.rx_valid) begin
        case (st_q)
          PS_IDLE: begin
            if (ch == CH_SOH && !par_bad) begin
              st_q  <= PS_HDR;
              idx_q <= 3'h0;
              bcc_q <= 7'h00;
            end
          end
          PS_HDR: begin
            if (par_bad) begin
              frm.done <= 1'b1;
              frm.ok   <= 1'b0;
              st_q     <= PS_IDLE;
            end else if (!hdr_hit) begin
              // not an error reply: drop quietly
              st_q <= PS_IDLE;
            end else begin
              bcc_q <= bcc_q ^ ch;
              idx_q <= (idx_q == HDR_LAST) ? 3'h0 : idx_q + 3'h1;
              if (idx_q == HDR_LAST) begin
                st_q <= PS_DIG;
              end
            end
          end
          PS_DIG: begin
            if (par_bad || !is_digit) begin
              frm.done <= 1'b1;
              frm.ok   <= 1'b0;
              st_q     <= PS_IDLE;
            end else begin
              bcc_q   <= bcc_q ^ ch;
              frm.num <= {frm.num[7:0], ch[3:0]};
              idx_q   <= idx_q + 3'h1;
              if (idx_q[1:0] == DIG_LAST) begin
                st_q <= PS_ETB;
              end
            end
          end
          PS_ETB: begin
            if (par_bad || ch != CH_ETB) begin
              frm.done <= 1'b1;
              frm.ok   <= 1'b0;
              st_q     <= PS_IDLE;
            end else begin
              bcc_q <= bcc_q ^ ch;
              st_q  <= PS_BCC;
            end
          end
          PS_BCC: begin
            frm.done <= 1'b1;
            frm.ok   <= !par_bad && (ch == bcc_q);
            st_q     <= PS_IDLE;
          end
          default: st_q <= PS_IDLE;
        endcase
      end
    end
  end

  property p_hdr_drop;
    @(posedge pclk) disable iff (!presetn)
      (st_q == PS_HDR && frm.rx_valid && !par_bad && !hdr_hit) |=> (st_q == PS_IDLE && !frm.done);
  endproperty
  a_hdr_drop: assert property (p_hdr_drop) else $error("header mismatch not dropped");

  sequence s_check_char;
    st_q == PS_BCC && frm.rx_valid;
  endsequence
  property p_bcc;
    @(posedge pclk) disable iff (!presetn)
      s_check_char |=> frm.done && (frm.ok == ($past(ch) == $past(bcc_q) && !$past(par_bad)));
  endproperty
  a_bcc: assert property (p_bcc) else $error("check character verdict wrong");

  property p_par;
    @(posedge pclk) disable iff (!presetn)
      (st_q != PS_IDLE && frm.rx_valid && par_bad) |=> frm.done && !frm.ok;
  endproperty
  a_par: assert property (p_par) else $error("parity fault not reported");
endmodule : ster_frame_parser

// >>> core/ster_top.sv
// serial transfer error reporter: apb registers, error classing, frame decode
`timescale 1ns/10ps
module ster_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               rx_valid,
  input  wire logic [7:0]         rx_char,
  input  wire logic               rx_frame_err,
  input  wire logic               rx_overrun,
  input  wire logic               rx_parity_err,
  input  wire logic               rx_buf_ovf,
  input  wire logic               rx_esc_bad,
  input  wire logic               rx_almost_full,
  input  wire logic               nak_rx,
  input  wire logic               nak_tx,
  input  wire logic               xfer_start,
  input  wire logic               xfer_end,
  input  wire logic               prog_loaded,
  input  wire logic               dsr_n,
  output logic                    xoff_req,
  output logic                    irq
);
  import ster_pkg::*;

  if (ADDR_W < 5) begin : g_addr_chk
    $error("ADDR_W too small for register map");
  end

  ster_frm_if frm ();

  logic [CT_W-1:0]  ctrl_q;
  ster_mode_e       mode_a_q;
  ster_mode_e       mode_b_q;
  logic [ST_W-1:0]  sts_q;
  logic [ST_W-1:0]  sts_set;
  logic [ST_W-1:0]  sts_clr;
  logic [ST_W-1:0]  mask_q;
  logic [11:0]      num_q;
  ster_class_e      class_q;
  logic [6:0]       letter_q;
  logic [2:0]       nak_rx_cnt_q;
  logic [2:0]       nak_tx_cnt_q;
  logic             dsr_m_q;
  logic             dsr_s2_q;
  logic             dsr_s3_q;
  logic             dsr_ok_q;
  logic             full_q;
  logic             wr_en;
  logic             rd_en;
  logic             hit;
  logic [7:0]       ofs;
  logic [31:0]      rd_d;
  logic             fixed_mode;
  logic             floppy_on;
  logic             tape_on;
  logic             assign_wr;
  logic             assign_bad;
  ster_mode_e       req_mode;
  ster_mode_e       tgt_mode;
  logic             val_evt;
  logic             m_evt;
  logic             n_evt;
  logic             baud_bad;

  ster_frame_parser u_parser (
    .pclk    (pclk),
    .presetn (presetn),
    .frm     (frm.parser)
  );

  assign frm.rx_valid = rx_valid && floppy_on;
  assign frm.rx_char  = rx_char;

  // apb: one wait state, data and answer come from flops
  assign ofs   = 8'(paddr);
  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready && !pwrite;
  assign hit   = (ofs == OFS_CTRL) || (ofs == OFS_ASSIGN) || (ofs == OFS_STATUS)
              || (ofs == OFS_MASK) || (ofs == OFS_CODE);

  always_comb begin
    rd_d = 32'h0000_0000;
    case (ofs)
      OFS_CTRL:   rd_d[CT_W-1:0] = ctrl_q;
      OFS_ASSIGN: rd_d[3:0]      = {mode_b_q, mode_a_q};
      OFS_STATUS: rd_d[ST_W-1:0] = sts_q;
      OFS_MASK:   rd_d[ST_W-1:0] = mask_q;
      OFS_CODE: begin
        rd_d[11:0]                 = num_q;
        rd_d[CD_CLASS+1:CD_CLASS]  = class_q;
        rd_d[CD_LETTER+6:CD_LETTER] = letter_q;
        rd_d[CD_DSR]               = dsr_ok_q;
      end
      default:    rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !hit;
      if (rd_en) begin
        prdata <= rd_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      mask_q <= '0;
    end else if (wr_en && ofs == OFS_CTRL) begin
      ctrl_q <= pwdata[CT_W-1:0];
    end else if (wr_en && ofs == OFS_MASK) begin
      mask_q <= pwdata[ST_W-1:0];
    end
  end

  // interface assignment: a held interface only takes its own mode or release
  assign assign_wr  = wr_en && ofs == OFS_ASSIGN;
  assign req_mode   = ster_mode_e'(pwdata[1:0]);
  assign tgt_mode   = pwdata[AS_IFACE] ? mode_b_q : mode_a_q;
  assign assign_bad = assign_wr && tgt_mode != MD_NONE && req_mode != MD_NONE
                   && req_mode != tgt_mode;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_a_q <= MD_NONE;
      mode_b_q <= MD_NONE;
    end else if (assign_wr && !assign_bad) begin
      if (pwdata[AS_IFACE]) begin
        mode_b_q <= req_mode;
      end else begin
        mode_a_q <= req_mode;
      end
    end
  end

  assign floppy_on  = mode_a_q == MD_FLOPPY || mode_b_q == MD_FLOPPY;
  assign tape_on    = mode_a_q == MD_TAPE || mode_b_q == MD_TAPE;
  assign fixed_mode = floppy_on || tape_on;

  // three-stage pin sync; level accepted once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsr_m_q  <= 1'b1;
      dsr_s2_q <= 1'b1;
      dsr_s3_q <= 1'b1;
      dsr_ok_q <= 1'b0;
    end else begin
      dsr_m_q  <= dsr_n;
      dsr_s2_q <= dsr_m_q;
      dsr_s3_q <= dsr_s2_q;
      if (dsr_s2_q == dsr_s3_q) begin
        dsr_ok_q <= !dsr_s3_q;
      end
    end
  end

  // nak counters restart with each transfer, saturate above the limit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nak_rx_cnt_q <= 3'h0;
      nak_tx_cnt_q <= 3'h0;
    end else if (xfer_start) begin
      nak_rx_cnt_q <= 3'h0;
      nak_tx_cnt_q <= 3'h0;
    end else begin
      if (nak_rx && nak_rx_cnt_q <= NAK_LIMIT) begin
        nak_rx_cnt_q <= nak_rx_cnt_q + 3'h1;
      end
      if (nak_tx && nak_tx_cnt_q <= NAK_LIMIT) begin
        nak_tx_cnt_q <= nak_tx_cnt_q + 3'h1;
      end
    end
  end

  assign m_evt    = !xfer_start && nak_rx && nak_rx_cnt_q == NAK_LIMIT;
  assign n_evt    = !xfer_start && nak_tx && nak_tx_cnt_q == NAK_LIMIT;
  assign val_evt  = rx_frame_err || rx_overrun || rx_parity_err;
  assign baud_bad = ctrl_q[CT_ACT_A] && ctrl_q[CT_ACT_B]
                 && ctrl_q[CT_BAUD_A+3:CT_BAUD_A] != ctrl_q[CT_BAUD_B+3:CT_BAUD_B];

  always_comb begin
    sts_set             = '0;
    sts_set[ST_FRAME]   = frm.done;
    sts_set[ST_VALUE]   = val_evt || rx_buf_ovf || (rx_esc_bad && tape_on);
    sts_set[ST_NAK_RX]  = m_evt;
    sts_set[ST_NAK_TX]  = n_evt;
    sts_set[ST_BAUD]    = baud_bad;
    sts_set[ST_ASSIGN]  = assign_bad;
    sts_set[ST_NOTRDY]  = !dsr_ok_q;
    sts_set[ST_INCOMPL] = xfer_end && !prog_loaded;
    sts_clr             = (wr_en && ofs == OFS_STATUS) ? pwdata[ST_W-1:0] : '0;
  end

  // set beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= '0;
      irq   <= 1'b0;
    end else begin
      sts_q <= (sts_q & ~sts_clr) | sts_set;
      irq   <= |(sts_q & mask_q);
    end
  end

  // letter code: value combination first, then H, K, M, N
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      letter_q <= 7'h00;
    end else if (val_evt) begin
      letter_q <= LT_BASE | {4'h0, rx_parity_err, rx_overrun, rx_frame_err};
    end else if (rx_buf_ovf) begin
      letter_q <= LT_H;
    end else if (rx_esc_bad && tape_on) begin
      letter_q <= LT_K;
    end else if (m_evt) begin
      letter_q <= LT_M;
    end else if (n_evt) begin
      letter_q <= LT_N;
    end
  end

  // a failed check stands in as a faulty-transfer number
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      num_q   <= 12'h000;
      class_q <= CL_NONE;
    end else if (frm.done) begin
      num_q <= frm.ok ? frm.num : NUM_FAULTY;
      if (!frm.ok) begin
        class_q <= CL_IO;
      end else if (frm.num[11:4] == 8'h00 && frm.num[3:0] != 4'h0
                   && frm.num[3:0] <= 4'h7) begin
        class_q <= CL_IO;
      end else if (frm.num[11:4] == 8'h01 && frm.num[3:0] <= 4'h8) begin
        class_q <= CL_RW;
      end else if (frm.num[11:4] == 8'h10 && frm.num[3:0] <= 4'h9) begin
        class_q <= CL_DISK;
      end else begin
        class_q <= CL_NONE;
      end
    end
  end

  // DC3 request on the rising near-full edge, fixed modes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q   <= 1'b0;
      xoff_req <= 1'b0;
    end else begin
      full_q   <= rx_almost_full;
      xoff_req <= rx_almost_full && !full_q && fixed_mode;
    end
  end

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing wrong");

  property p_nak_m;
    @(posedge pclk) disable iff (!presetn)
      (nak_rx && !xfer_start && nak_rx_cnt_q == 3'h3) |=> sts_q[ST_NAK_RX] && letter_q != 7'h00;
  endproperty
  a_nak_m: assert property (p_nak_m) else $error("fourth received nak not flagged");

  property p_nak_n_early;
    @(posedge pclk) disable iff (!presetn)
      (xfer_start ##1 (!nak_tx && !xfer_start)[*3]) |-> nak_tx_cnt_q == 3'h0;
  endproperty
  a_nak_n_early: assert property (p_nak_n_early) else $error("nak count not restarted");

  property p_value_g;
    @(posedge pclk) disable iff (!presetn)
      (rx_frame_err && rx_overrun && rx_parity_err) |=> letter_q == 7'h47 && sts_q[ST_VALUE];
  endproperty
  a_value_g: assert property (p_value_g) else $error("all three faults not letter G");

  property p_k_tape;
    @(posedge pclk) disable iff (!presetn)
      (rx_esc_bad && !tape_on && !val_evt && !rx_buf_ovf) |=> $stable(letter_q) || letter_q != LT_K;
  endproperty
  a_k_tape: assert property (p_k_tape) else $error("escape letter outside tape mode");

  property p_baud;
    @(posedge pclk) disable iff (!presetn)
      baud_bad [*2] |-> sts_q[ST_BAUD] [*2];
  endproperty
  a_baud: assert property (p_baud) else $error("baud mismatch not flagged");

  property p_assign;
    @(posedge pclk) disable iff (!presetn)
      assign_bad |=> $stable(mode_a_q) && $stable(mode_b_q) && sts_q[ST_ASSIGN];
  endproperty
  a_assign: assert property (p_assign) else $error("double assignment accepted");

  property p_notrdy;
    @(posedge pclk) disable iff (!presetn)
      (dsr_n [*4]) |-> ##2 sts_q[ST_NOTRDY];
  endproperty
  a_notrdy: assert property (p_notrdy) else $error("missing dsr not reported");

  property p_incompl;
    @(posedge pclk) disable iff (!presetn)
      (xfer_end && !prog_loaded) |=> sts_q[ST_INCOMPL];
  endproperty
  a_incompl: assert property (p_incompl) else $error("early end not reported");

  property p_disk_class;
    @(posedge pclk) disable iff (!presetn)
      (frm.done && frm.ok && frm.num == 12'h109) |=> class_q == CL_DISK && num_q == 12'h109;
  endproperty
  a_disk_class: assert property (p_disk_class) else $error("number 109 misclassed");
endmodule : ster_top

// >>> verif/ster_periph.sv
// peripheral model: floppy reply frames, nak and data-set-ready
`timescale 1ns/10ps
module ster_periph (
  input  wire logic  pclk,
  input  wire logic  xoff_req,
  output logic       rx_valid,
  output logic [7:0] rx_char,
  output logic       nak_rx,
  output logic       dsr_n
);
  import ster_pkg::*;
  logic [3:0] pause_q;
  initial begin
    rx_valid = 1'b0;
    rx_char  = 8'h55;
    nak_rx   = 1'b0;
    dsr_n    = 1'b1;
    pause_q  = 4'h0;
  end
  // dc3 seen: hold back the next character for a while
  always @(posedge pclk) pause_q <= xoff_req ? 4'hf : pause_q - 4'(pause_q != 4'h0);
  task send(input logic [6:0] c);
    @(posedge pclk);
    while (pause_q != 4'h0) @(posedge pclk);
    rx_valid <= 1'b1;
    rx_char  <= {^c, c};
    @(posedge pclk);
    rx_valid <= 1'b0;
    // idle line shows junk, not the last character
    rx_char  <= ~rx_char;
    repeat ($urandom_range(3)) @(posedge pclk);
  endtask : send
  task send_frame(input logic [11:0] num, input logic bad);
    logic [6:0] s [11];
    logic [6:0] bcc;
    s = '{CH_E, CH_R, CH_R, CH_COLON, CH_SP, CH_SP, CH_SP, CH_ZERO + 7'(num[11:8]),
          CH_ZERO + 7'(num[7:4]), CH_ZERO + 7'(num[3:0]), CH_ETB};
    bcc = 7'h0;
    send(CH_SOH);
    foreach (s[i]) begin
      send(s[i]);
      bcc ^= s[i];
    end
    send(bcc ^ {6'h0, bad});
  endtask : send_frame
  task set_dsr(input logic on);
    @(posedge pclk);
    dsr_n <= !on;
  endtask : set_dsr
  task nak();
    @(posedge pclk);
    nak_rx <= 1'b1;
    @(posedge pclk);
    nak_rx <= 1'b0;
  endtask : nak
endmodule : ster_periph

// >>> verif/tb_serial_transfer_error_reporter.sv
// self-checking bench for the serial transfer error reporter
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_serial_transfer_error_reporter;
  import ster_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, ev, rx_char;
  logic [31:0] pwdata, prdata;
  logic        rx_valid, nak_rx, dsr_n, rx_almost_full, prog_loaded, xoff_req, irq, dsr_on;
  logic [32:0] exp_q [$];
  logic [32:0] ex;
  logic [6:0]  lt;
  logic [11:0] num;
  int          n_errors, comparisons, cyc;
  logic [11:0] nums [8] = '{12'h001, 12'h005, 12'h007, 12'h010, 12'h018, 12'h109, 12'h050,
                            12'h000};

  ster_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_char(rx_char), .rx_frame_err(ev[0]),
    .rx_overrun(ev[1]), .rx_parity_err(ev[2]), .rx_buf_ovf(ev[3]), .rx_esc_bad(ev[4]),
    .rx_almost_full(rx_almost_full), .nak_rx(nak_rx), .nak_tx(ev[5]), .xfer_start(ev[6]),
    .xfer_end(ev[7]), .prog_loaded(prog_loaded), .dsr_n(dsr_n), .xoff_req(xoff_req),
    .irq(irq));
  ster_periph u_per (.pclk(pclk), .xoff_req(xoff_req), .rx_valid(rx_valid),
    .rx_char(rx_char), .nak_rx(nak_rx), .dsr_n(dsr_n));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  function automatic logic [32:0] code();
    logic [1:0] c;
    c = (num >= 12'h001 && num <= 12'h007) ? 2'h1 : (num >= 12'h010 && num <= 12'h018) ? 2'h2 :
        (num >= 12'h100 && num <= 12'h109) ? 2'h3 : 2'h0;
    return {8'h0, dsr_on, 1'b0, lt, 2'h0, c, num};
  endfunction : code

  task finish_test();
    // a read that never completed leaves its note behind
    if (exp_q.size() != 0) n_errors++;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  task pulse(input logic [7:0] m);
    @(posedge pclk);
    ev <= m;
    @(posedge pclk);
    ev <= 8'h0;
  endtask : pulse
  task chk_irq(input logic e);
    @(negedge pclk);
    `CHK("irq", e, irq)
  endtask : chk_irq

  always @(posedge pclk) if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
    ex = exp_q.pop_front();
    `CHK("apb read", ex, {pslverr, prdata})
  end

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev, rx_almost_full, prog_loaded} = '0;
    {presetn, n_errors, comparisons, cyc, lt, dsr_on} = '0;
    void'($urandom(32'he861a7d7));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, 33'h0);
    rd(OFS_MASK, 33'h0);
    rd(OFS_STATUS, 33'h40);
    rd(8'h14, 33'h1_0000_0000);
    u_per.set_dsr(1'b1);
    dsr_on = 1'b1;
    repeat (8) @(posedge pclk);
    wr(OFS_STATUS, 32'hff);
    rd(OFS_STATUS, 33'h0);
    wr(OFS_ASSIGN, 32'h1);
    wr(OFS_ASSIGN, 32'h2);
    rd(OFS_ASSIGN, 33'h1);
    rd(OFS_STATUS, 33'h20);
    wr(OFS_ASSIGN, 32'h0);
    wr(OFS_ASSIGN, 32'h2);
    wr(OFS_ASSIGN, 32'h101);
    rd(OFS_ASSIGN, 33'h6);
    wr(OFS_MASK, 32'h10);
    wr(OFS_CTRL, 32'h353);
    rd(OFS_STATUS, 33'h30);
    chk_irq(1'b1);
    wr(OFS_CTRL, 32'h333);
    wr(OFS_STATUS, 32'hff);
    rd(OFS_CTRL, 33'h333);
    rd(OFS_STATUS, 33'h0);
    chk_irq(1'b0);
    foreach (nums[k]) begin
      num = (k == 7) ? 12'h100 + 12'($urandom_range(9)) : nums[k];
      u_per.send_frame(num, 1'b0);
      repeat (4) @(posedge pclk);
      rd(OFS_CODE, code());
    end
    rd(OFS_STATUS, 33'h1);
    u_per.send_frame(12'h014, 1'b1);
    num = NUM_FAULTY;
    repeat (4) @(posedge pclk);
    rd(OFS_CODE, code());
    wr(OFS_STATUS, 32'hff);
    // a start without the error header must be dropped quietly
    u_per.send(CH_SOH);
    u_per.send(CH_R);
    for (int i = 1; i < 8; i++) begin
      pulse(8'(i));
      lt = LT_BASE + 7'(i);
      rd(OFS_CODE, code());
    end
    pulse(8'h08);
    lt = LT_H;
    rd(OFS_CODE, code());
    pulse(8'h10);
    lt = LT_K;
    rd(OFS_CODE, code());
    rd(OFS_STATUS, 33'h2);
    wr(OFS_STATUS, 32'hff);
    pulse(8'h40);
    repeat (3) u_per.nak();
    repeat (3) pulse(8'h20);
    rd(OFS_STATUS, 33'h0);
    u_per.nak();
    lt = LT_M;
    rd(OFS_STATUS, 33'h4);
    rd(OFS_CODE, code());
    pulse(8'h20);
    lt = LT_N;
    rd(OFS_STATUS, 33'hc);
    rd(OFS_CODE, code());
    wr(OFS_STATUS, 32'hff);
    pulse(8'h80);
    rd(OFS_STATUS, 33'h80);
    wr(OFS_STATUS, 32'hff);
    prog_loaded <= 1'b1;
    pulse(8'h80);
    rd(OFS_STATUS, 33'h0);
    @(posedge pclk);
    rx_almost_full <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    `CHK("xoff", 1'b1, xoff_req)
    @(negedge pclk);
    `CHK("xoff", 1'b0, xoff_req)
    u_per.set_dsr(1'b0);
    dsr_on = 1'b0;
    repeat (8) @(posedge pclk);
    rd(OFS_STATUS, 33'h40);
    rd(OFS_CODE, code());
    chk_irq(1'b0);
    finish_test();
  end
endmodule : tb_serial_transfer_error_reporter
